// ==== logic/smbs_pkg.sv ====
// Purpose: Shared constants for the static memory bus sequencer
// Assumes: Core clock of 250 MHz; expansion clock made from it by a divider
// Notes: Times are in ns; cycle counts derive from them
`default_nettype none
package smbs_pkg;
	// Core clock period
	localparam int CLK_PERIOD_NS = 4;
	// Expansion clock period at the fastest documented rate
	localparam int EXP_PERIOD_NS = 22;
	// Half period in core cycles, rounded up so the period is never short
	localparam int EXP_HALF_CYC = (EXP_PERIOD_NS + 2 * CLK_PERIOD_NS - 1) / (2 * CLK_PERIOD_NS);
	// Divider counter width
	localparam int DIV_W = 4;
	// Address space split
	localparam int BANKS = 6;
	localparam int REGION_W = 28;
	localparam int SEL_LSB = 28;
	// Wait-state field width
	localparam int WS_W = 4;
	// Burst length limits
	localparam logic [2:0] BURST_MIN = 3'h2;
	localparam logic [2:0] BURST_MAX = 3'h4;
	// Least wait states for a first access and for any write
	localparam logic [3:0] WS_FLOOR = 4'h1;
	// Reset value of every strobe and select
	localparam logic STROBE_IDLE = 1'b1;
	// Bank data path width codes
	typedef enum logic [1:0] {
		SMBS_W8 = 2'h0,
		SMBS_W16 = 2'h1,
		SMBS_W32 = 2'h2
	} smbs_width_t;
endpackage
`default_nettype wire

// ==== logic/smbs_sequencer.sv ====
// Purpose: Static memory and expansion bus cycle sequencer
// Assumes: Inputs synchronous to clk_in; one request at a time
// Notes: Expansion clock is driven out; all strobes move on its edges
`default_nettype none
module smbs_sequencer #(
	parameter int HALF_CYC = smbs_pkg::EXP_HALF_CYC
) (
	// Clock and reset
	input wire logic clk_in,
	input wire logic srst_in,
	// Configuration
	input wire logic [smbs_pkg::WS_W-1:0] nonseq_wait_in,
	input wire logic [smbs_pkg::WS_W-1:0] seq_wait_in,
	input wire logic [2:0] burst_len_in,
	input wire logic sequential_access_enable_in,
	input wire logic [2*smbs_pkg::BANKS-1:0] bank_width_in,
	// Request
	input wire logic req_valid_in,
	input wire logic req_write_in,
	input wire logic req_burst_in,
	input wire logic [31:0] req_addr_in,
	input wire logic [31:0] req_wdata_in,
	output logic req_ready_out,
	// Answer
	output logic rd_valid_out,
	output logic [31:0] rd_data_out,
	output logic done_out,
	output logic err_out,
	// Memory pins
	output logic expansion_bus_clock_out,
	input wire logic far_device_ready_in,
	output logic [smbs_pkg::BANKS-1:0] bank_select_n_out,
	output logic static_output_enable_n_out,
	output logic static_write_strobe_n_out,
	output logic [smbs_pkg::REGION_W-1:0] addr_out,
	output logic word_out,
	output logic halfword_out,
	output logic write_out,
	input wire logic [31:0] data_in,
	output logic [31:0] data_out,
	output logic data_oe_out
);
	typedef enum {S_IDLE, S_ACT, S_WREL, S_GAP} smbs_state_t;

	// Divider state
	logic [smbs_pkg::DIV_W-1:0] div_q, div_d;
	logic exp_clk_q, exp_clk_d;
	logic tick, rise, fall; // Edge enables, valid in the cycle the clock toggles

	// Divider: next values
	always_comb
	begin
		tick = (div_q == smbs_pkg::DIV_W'(HALF_CYC - 1));
		rise = tick && !exp_clk_q;
		fall = tick && exp_clk_q;
		div_d = tick ? '0 : div_q + 1'b1;
		exp_clk_d = tick ? !exp_clk_q : exp_clk_q;
	end

	// Divider: registers
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			div_q <= '0;
			exp_clk_q <= 1'b0;
		end
		else
		begin
			div_q <= div_d;
			exp_clk_q <= exp_clk_d;
		end
	end

	// Sequencer state
	smbs_state_t state_q, state_d;
	logic [smbs_pkg::BANKS-1:0] cs_n_q, cs_n_d; // One select per mapped region, regions 0 to 5
	logic oe_n_q, oe_n_d;
	logic we_n_q, we_n_d;
	logic [smbs_pkg::REGION_W-1:0] addr_q, addr_d;
	logic [31:0] wdata_q, wdata_d;
	logic data_oe_q, data_oe_d;
	logic word_q, word_d;
	logic half_q, half_d;
	logic write_q, write_d;
	logic [smbs_pkg::WS_W-1:0] waits_q, waits_d; // Remaining whole periods
	logic [2:0] beats_q, beats_d; // Remaining read beats
	logic adv_q, adv_d; // Address step due at next rise
	logic [31:0] rdata_q, rdata_d;
	logic rd_valid_q, rd_valid_d;
	logic done_q, done_d;
	logic err_q, err_d;
	logic ready_q, ready_d;
	// Request decode
	logic accept;
	logic [3:0] region;
	logic [1:0] width;
	logic [2:0] blen;
	logic [smbs_pkg::WS_W-1:0] first_ws;

	// Sequencer: next values
	always_comb
	begin
		state_d = state_q;
		cs_n_d = cs_n_q;
		oe_n_d = oe_n_q;
		we_n_d = we_n_q;
		addr_d = addr_q;
		wdata_d = wdata_q;
		data_oe_d = data_oe_q;
		word_d = word_q;
		half_d = half_q;
		write_d = write_q;
		waits_d = waits_q;
		beats_d = beats_q;
		adv_d = adv_q;
		rdata_d = rdata_q;
		rd_valid_d = 1'b0;
		done_d = 1'b0;
		err_d = 1'b0;
		accept = req_valid_in && ready_q && rise;
		region = req_addr_in[smbs_pkg::SEL_LSB +: 4];
		width = bank_width_in[2 * region[2:0] +: 2];
		// Burst length clamped to the legal range
		blen = (burst_len_in < smbs_pkg::BURST_MIN) ? smbs_pkg::BURST_MIN
			: (burst_len_in > smbs_pkg::BURST_MAX) ? smbs_pkg::BURST_MAX
			: burst_len_in;
		// First access never faster than one wait state; also keeps writes legal
		first_ws = (nonseq_wait_in < smbs_pkg::WS_FLOOR) ? smbs_pkg::WS_FLOOR
			: nonseq_wait_in;
		unique case (state_q)
			S_IDLE:
			begin
				if (accept)
				begin
					if (region >= 4'(smbs_pkg::BANKS))
						err_d = 1'b1; // Unmapped region: no bus cycle
					else
					begin
						cs_n_d = ~(smbs_pkg::BANKS'(1) << region);
						addr_d = req_addr_in[smbs_pkg::REGION_W-1:0];
						write_d = req_write_in;
						word_d = (width == smbs_pkg::SMBS_W32);
						half_d = (width == smbs_pkg::SMBS_W16);
						waits_d = first_ws;
						adv_d = 1'b0;
						if (req_write_in)
						begin
							wdata_d = req_wdata_in;
							data_oe_d = 1'b1;
							we_n_d = 1'b0;
							beats_d = 3'h1;
						end
						else
							beats_d = req_burst_in ? blen : 3'h1;
						state_d = S_ACT;
					end
				end
			end
			S_ACT:
			begin
				// Address step for next beat lands after a rise
				if (rise && adv_q)
				begin
					adv_d = 1'b0;
					addr_d = addr_q + (word_q ? 28'h4 : (half_q ? 28'h2 : 28'h1));
				end
				if (fall)
				begin
					if (!write_q)
						oe_n_d = 1'b0;
					if (waits_q != '0)
						waits_d = waits_q - 1'b1; // One whole period per wait
					else if (far_device_ready_in)
					begin
						if (write_q)
							state_d = S_WREL;
						else
						begin
							rdata_d = data_in;
							rd_valid_d = 1'b1;
							if (beats_q == 3'h1)
							begin
								oe_n_d = smbs_pkg::STROBE_IDLE;
								cs_n_d = '1;
								done_d = 1'b1;
								// Sequential mode skips the idle period
								state_d = sequential_access_enable_in ? S_IDLE : S_GAP;
							end
							else
							begin
								beats_d = beats_q - 1'b1;
								adv_d = 1'b1;
								waits_d = sequential_access_enable_in ? seq_wait_in
									: nonseq_wait_in;
							end
						end
					end
					// Ready low: no transfer, try again next fall
				end
			end
			S_WREL:
			begin
				// Strobe lifts on the rise, then select and data on the fall
				if (rise && !we_n_q)
					we_n_d = smbs_pkg::STROBE_IDLE;
				else if (fall && we_n_q)
				begin
					cs_n_d = '1;
					data_oe_d = 1'b0;
					done_d = 1'b1;
					// Address, data, size and direction left as they are
					state_d = sequential_access_enable_in ? S_IDLE : S_GAP;
				end
			end
			S_GAP:
			begin
				// One full idle expansion period between cycles
				if (fall)
					state_d = S_IDLE;
			end
		endcase
		ready_d = (state_d == S_IDLE) && !accept;
	end

	// Sequencer: registers
	always_ff @(posedge clk_in)
	begin
		if (srst_in)
		begin
			state_q <= S_IDLE;
			cs_n_q <= '1;
			oe_n_q <= smbs_pkg::STROBE_IDLE;
			we_n_q <= smbs_pkg::STROBE_IDLE;
			addr_q <= '0;
			wdata_q <= '0;
			data_oe_q <= 1'b0;
			word_q <= 1'b0;
			half_q <= 1'b0;
			write_q <= 1'b0;
			waits_q <= '0;
			beats_q <= '0;
			adv_q <= 1'b0;
			rdata_q <= '0;
			rd_valid_q <= 1'b0;
			done_q <= 1'b0;
			err_q <= 1'b0;
			ready_q <= 1'b0;
		end
		else
		begin
			state_q <= state_d;
			cs_n_q <= cs_n_d;
			oe_n_q <= oe_n_d;
			we_n_q <= we_n_d;
			addr_q <= addr_d;
			wdata_q <= wdata_d;
			data_oe_q <= data_oe_d;
			word_q <= word_d;
			half_q <= half_d;
			write_q <= write_d;
			waits_q <= waits_d;
			beats_q <= beats_d;
			adv_q <= adv_d;
			rdata_q <= rdata_d;
			rd_valid_q <= rd_valid_d;
			done_q <= done_d;
			err_q <= err_d;
			ready_q <= ready_d;
		end
	end

	// Outputs straight from flops
	assign expansion_bus_clock_out = exp_clk_q;
	assign bank_select_n_out = cs_n_q;
	assign static_output_enable_n_out = oe_n_q;
	assign static_write_strobe_n_out = we_n_q;
	assign addr_out = addr_q;
	assign word_out = word_q;
	assign halfword_out = half_q;
	assign write_out = write_q;
	assign data_out = wdata_q;
	assign data_oe_out = data_oe_q;
	assign rd_data_out = rdata_q;
	assign rd_valid_out = rd_valid_q;
	assign done_out = done_q;
	assign err_out = err_q;
	assign req_ready_out = ready_q;

	// Checks on edge placement, holding, write wait states, ready stalls, burst length, select and size codes
	cs_edge_a: assert property (@(posedge clk_in) disable iff (srst_in)
		($fell(&cs_n_q) |-> $past(rise)) and ($rose(&cs_n_q) |-> $past(fall)))
		else $error("select moved on wrong edge");
	oe_edge_a: assert property (@(posedge clk_in) disable iff (srst_in)
		$changed(oe_n_q) |-> $past(fall)) else $error("output enable moved off a falling edge");
	we_edge_a: assert property (@(posedge clk_in) disable iff (srst_in)
		$changed(we_n_q) |-> $past(rise)) else $error("write strobe moved off a rising edge");
	wdata_window_a: assert property (@(posedge clk_in) disable iff (srst_in)
		($rose(data_oe_q) |-> $past(rise)) and ($fell(data_oe_q) |-> $past(fall)))
		else $error("write data window misplaced");
	write_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q != S_ACT) && !accept |=> $stable(addr_q) && $stable(wdata_q)
		&& $stable(word_q) && $stable(half_q) && $stable(write_q))
		else $error("bus values changed between cycles");
	write_ws_a: assert property (@(posedge clk_in) disable iff (srst_in)
		$fell(we_n_q) |-> waits_q != '0) else $error("write began with zero wait states");
	stretch_hold_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == S_ACT) && (waits_q != '0) && !adv_q |=> $stable(cs_n_q) && $stable(addr_q))
		else $error("stretched cycle did not hold");
	ready_wait_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == S_ACT) && fall && (waits_q == '0) && !far_device_ready_in
		|=> !rd_valid_q && state_q == S_ACT)
		else $error("transfer despite ready low");
	burst_len_a: assert property (@(posedge clk_in) disable iff (srst_in)
		(state_q == S_ACT) |-> (beats_q != 3'h0) && (beats_q <= smbs_pkg::BURST_MAX))
		else $error("burst beat count out of range");
	one_select_a: assert property (@(posedge clk_in) disable iff (srst_in)
		$onehot0(~cs_n_q)) else $error("more than one bank selected");
	size_code_a: assert property (@(posedge clk_in) disable iff (srst_in)
		!(word_q && half_q)) else $error("word and halfword both high");
endmodule
`default_nettype wire

// ==== tb/smbs_mem_model.sv ====
// Purpose: Far-side static memory model for the sequencer bench
// Assumes: Pins as driven by the sequencer, sampled on the core clock
// Notes: Read data is a function of address; ready stall length comes from the bench
`default_nettype none
module smbs_mem_model (
	// Clock
	input wire logic clk_in,
	// Pins from the sequencer
	input wire logic [5:0] sel_n_in,
	input wire logic oe_n_in,
	input wire logic we_n_in,
	input wire logic ck_in,
	input wire logic [27:0] addr_in,
	input wire logic [31:0] wdata_in,
	input wire logic data_oe_in,
	// Bench control
	input wire logic [3:0] stall_in,
	// Pins toward the sequencer, and last write data seen for the bench
	output logic [31:0] rdata_out,
	output logic ready_out,
	output logic [31:0] wr_seen_out
);
	timeunit 1ns;
	timeprecision 1ps;
	// Falls still to hold ready low
	logic [3:0] left_q = 4'h0;
	// Previous pin levels
	logic ck_q = 1'b0;
	logic we_q = 1'b1;
	logic idle_q = 1'b1;
	// Toggling junk so a released bus never looks valid
	logic [31:0] junk_q = 32'h0;
	// Last write data seen at strobe release; one driver for the port
	logic [31:0] seen_q = 32'h0;
	assign wr_seen_out = seen_q;
	// Combinational like a real part: new address gives new data at once
	assign rdata_out = (&sel_n_in | oe_n_in) ? junk_q : {addr_in, 4'h5};
	assign ready_out = (left_q == 4'h0);
	// Stall counted in falls from the start of each cycle
	always @(posedge clk_in)
	begin
		junk_q <= ~junk_q;
		ck_q <= ck_in;
		we_q <= we_n_in;
		idle_q <= &sel_n_in;
		if (idle_q && !(&sel_n_in))
			left_q <= stall_in;
		else if (ck_q && !ck_in && !(oe_n_in && we_n_in) && left_q != 4'h0)
			left_q <= left_q - 4'h1;
		// Data must still be driven when the strobe lets go
		if (!we_q && we_n_in && data_oe_in)
			seen_q <= wdata_in;
	end
endmodule
`default_nettype wire

// ==== tb/testbench.sv ====
// Purpose: Self-checking bench for the static memory bus sequencer
// Assumes: Short expansion half period to keep the run brief
// Notes: Inputs change on falling core clock edges
`default_nettype none
module testbench;
	timeunit 1ns;
	timeprecision 1ps;
	// Half period and full expansion period in core cycles
	localparam int HC = 1;
	localparam int P = 2 * HC;
	logic clk_in = 1'b0;
	logic srst_in = 1'b1;
	logic [3:0] nonseq_wait_in = 4'h1;
	logic [3:0] seq_wait_in = 4'h0;
	logic [2:0] burst_len_in = 3'h4;
	logic sequential_access_enable_in = 1'b0;
	logic [11:0] bank_width_in = {6'h0, smbs_pkg::SMBS_W16, smbs_pkg::SMBS_W32, smbs_pkg::SMBS_W8};
	logic req_valid_in = 1'b0;
	logic req_write_in = 1'b0;
	logic req_burst_in = 1'b0;
	logic [31:0] req_addr_in = 32'h0;
	logic [31:0] req_wdata_in = 32'h0;
	logic req_ready_out, rd_valid_out, done_out, err_out, ck, rdy, oe_n, we_n;
	logic word_out, halfword_out, write_out, data_oe_out;
	logic [5:0] sel_n;
	logic [27:0] addr_out;
	logic [31:0] rd_data_out, data_in, data_out, wr_seen;
	logic [3:0] stall = 4'h0;
	// Result counters and per-transfer records
	int n_fail = 0;
	int checked = 0;
	int cyc, r, k, c0;
	logic [31:0] rq[$];
	int bt[$];
	logic [5:0] sel_seen, es;
	logic err_seen;
	logic [1:0] w;
	logic [2:0] bl[4] = '{3'h2, 3'h3, 3'h4, 3'h7};
	int be[4] = '{2, 3, 4, 4};
	logic ck_p = 1'b0;
	logic oe_p = 1'b1;
	logic we_p = 1'b1;
	logic [5:0] sel_p = 6'h3f;
	smbs_sequencer #(.HALF_CYC(HC)) u_smbs_sequencer (.clk_in(clk_in), .srst_in(srst_in),
		.nonseq_wait_in(nonseq_wait_in), .seq_wait_in(seq_wait_in),
		.burst_len_in(burst_len_in), .bank_width_in(bank_width_in),
		.sequential_access_enable_in(sequential_access_enable_in),
		.req_valid_in(req_valid_in), .req_write_in(req_write_in),
		.req_burst_in(req_burst_in), .req_addr_in(req_addr_in),
		.req_wdata_in(req_wdata_in), .req_ready_out(req_ready_out),
		.rd_valid_out(rd_valid_out), .rd_data_out(rd_data_out), .done_out(done_out),
		.err_out(err_out), .expansion_bus_clock_out(ck), .far_device_ready_in(rdy),
		.bank_select_n_out(sel_n), .static_output_enable_n_out(oe_n),
		.static_write_strobe_n_out(we_n), .addr_out(addr_out), .word_out(word_out),
		.halfword_out(halfword_out), .write_out(write_out), .data_in(data_in),
		.data_out(data_out), .data_oe_out(data_oe_out));
	smbs_mem_model u_smbs_mem_model (.clk_in(clk_in), .sel_n_in(sel_n), .oe_n_in(oe_n),
		.we_n_in(we_n), .ck_in(ck), .addr_in(addr_out), .wdata_in(data_out),
		.data_oe_in(data_oe_out), .stall_in(stall), .rdata_out(data_in), .ready_out(rdy),
		.wr_seen_out(wr_seen));
	// Core clock, 4 ns
	initial
	begin
		forever #2 clk_in = ~clk_in;
	end
	// Compare one value and count it
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checked++;
		if (s !== e)
		begin
			n_fail++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	// Counts, verdict and end of run
	task automatic print_verdict();
		$display("Checks %0d failures %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0)
			$display("ALL TESTS PASSED");
		else
			$display("TESTS FAILED");
		$finish;
	endtask
	// One request: wait for the take, then record beats until done or error
	task automatic xfer(input logic wr, input logic bst, input logic [31:0] a,
		input logic [31:0] wd);
		logic pr;
		int n;
		rq.delete();
		bt.delete();
		sel_seen = 6'h3f;
		err_seen = 1'b0;
		cyc = 0;
		pr = 1'b0;
		req_write_in = wr;
		req_burst_in = bst;
		req_addr_in = a;
		req_wdata_in = wd;
		req_valid_in = 1'b1;
		for (n = 0; n < 400 && !(pr && !req_ready_out); n++)
		begin
			pr = req_ready_out;
			@(negedge clk_in);
		end
		// Taken: drop the request before the next edge
		req_valid_in = 1'b0;
		for (; n < 400; n++)
		begin
			if (rd_valid_out === 1'b1)
			begin
				rq.push_back(rd_data_out);
				bt.push_back(cyc);
			end
			if (!(&sel_n))
				sel_seen = sel_n;
			err_seen |= err_out;
			if (done_out === 1'b1 || err_out === 1'b1)
				break;
			cyc++;
			@(negedge clk_in);
		end
		// A hang ends the run
		if (n >= 400)
		begin
			n_fail++;
			print_verdict();
		end
	endtask
	// Pins may only move on the matching expansion clock edge
	always @(negedge clk_in)
	begin
		if (oe_n != oe_p)
			chk("oe edge", 32'h1, 32'(ck_p & ~ck));
		if (we_n != we_p)
			chk("we edge", 32'h1, 32'(~ck_p & ck));
		if (&sel_p && !(&sel_n))
			chk("sel on edge", 32'h1, 32'(~ck_p & ck));
		if (!(&sel_p) && &sel_n)
			chk("sel off edge", 32'h1, 32'(ck_p & ~ck));
		ck_p = ck;
		oe_p = oe_n;
		we_p = we_n;
		sel_p = sel_n;
	end
	initial
	begin
		repeat (12) @(negedge clk_in);
		srst_in = 1'b0;
		repeat (3) @(negedge clk_in);
		chk("sel idle", 32'h3f, 32'(sel_n));
		// Regions 0 to 6 once; the seventh has no select
		for (r = 0; r < 7; r++)
		begin
			xfer(1'b0, 1'b0, {4'(r), 28'h10}, 32'h0);
			es = (r < 6) ? ~(6'h1 << r) : 6'h3f;
			w = bank_width_in[2 * (r % 6) +: 2];
			chk("sel", 32'(es), 32'(sel_seen));
			chk("err", 32'(r >= 6), 32'(err_seen));
			if (r < 6)
			begin
				chk("rd data", {28'h10, 4'h5}, rq[0]);
				chk("size", (w == smbs_pkg::SMBS_W32) ? 32'h2 :
					(w == smbs_pkg::SMBS_W16) ? 32'h1 : 32'h0,
					32'({word_out, halfword_out}));
			end
		end
		// Write with a zero wait request, then hold check
		nonseq_wait_in = 4'h0;
		xfer(1'b1, 1'b0, 32'h1000_0100, 32'ha5c3_1e77);
		c0 = cyc;
		chk("wr data", 32'ha5c3_1e77, wr_seen);
		repeat (4) @(negedge clk_in);
		chk("hold addr", 32'h100, 32'(addr_out));
		chk("hold data", 32'ha5c3_1e77, data_out);
		chk("hold ctl", 32'h6, 32'({write_out, word_out, halfword_out}));
		nonseq_wait_in = 4'h1;
		xfer(1'b1, 1'b0, 32'h1000_0104, 32'h0f1e_2d3c);
		chk("wr floor", 32'(c0), 32'(cyc));
		// Two more low ready samples must cost exactly two periods
		stall = 4'h1;
		xfer(1'b0, 1'b0, 32'h1000_0008, 32'h0);
		c0 = cyc;
		stall = 4'h3;
		xfer(1'b0, 1'b0, 32'h1000_0008, 32'h0);
		chk("stretch", 32'(c0 + 2 * P), 32'(cyc));
		chk("stretch data", {28'h8, 4'h5}, rq[0]);
		stall = 4'h0;
		// Burst lengths; a value above four is clamped
		for (k = 0; k < 4; k++)
		begin
			burst_len_in = bl[k];
			xfer(1'b0, 1'b1, 32'h2000_0040, 32'h0);
			chk("beats", 32'(be[k]), 32'(rq.size()));
			chk("beat last", {28'h40 + 28'(2 * be[k] - 2), 4'h5}, rq[be[k] - 1]);
		end
		// An idle period follows each cycle unless sequential mode is on
		chk("gap", 32'h0, 32'(req_ready_out));
		// Sequential mode uses its own wait count between beats
		sequential_access_enable_in = 1'b1;
		xfer(1'b0, 1'b1, 32'h2000_0040, 32'h0);
		chk("seq gap", 32'(P), 32'(bt[1] - bt[0]));
		chk("seq no idle", 32'h1, 32'(req_ready_out));
		seq_wait_in = 4'h2;
		xfer(1'b0, 1'b1, 32'h2000_0040, 32'h0);
		chk("seq wait", 32'(3 * P), 32'(bt[2] - bt[1]));
		print_verdict();
	end
endmodule
`default_nettype wire
